/* File: inc/tqp_consts.svh */
// Offsets, field positions, label codes and widths of the trace qualifier.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef TQP_CONSTS_SVH
`define TQP_CONSTS_SVH
`define TQP_ADDR_W      32
`define TQP_DATA_W      32
`define TQP_STAT_W      16
`define TQP_NPAT        8
`define TQP_NTERM       11
`define TQP_BUS_AW      9
`define TQP_OFF_CTRL    9'h000
`define TQP_OFF_PRESEL  9'h004
`define TQP_OFF_TRIGOR  9'h008
`define TQP_OFF_TRIGAND 9'h00c
`define TQP_OFF_STORE   9'h010
`define TQP_OFF_PREMASK 9'h014
`define TQP_OFF_RNGCFG  9'h018
`define TQP_OFF_RNGLO   9'h01c
`define TQP_OFF_RNGHI   9'h020
`define TQP_OFF_STATUS  9'h024
`define TQP_OFF_MEMIDX  9'h028
`define TQP_OFF_MEMA    9'h02c
`define TQP_OFF_MEMD    9'h030
`define TQP_OFF_MEMS    9'h034
`define TQP_PAT_BASE_BIT 8
`define TQP_CTRL_COMPLEX 0
`define TQP_CTRL_INIT    1
`define TQP_CTRL_RUN     2
`define TQP_STORE_ALL    16
`define TQP_TERM_RNG     8
`define TQP_TERM_NRNG    9
`define TQP_TERM_ARM     10
`define TQP_LAB_ADDR     2'h0
`define TQP_LAB_DATA     2'h1
`define TQP_LAB_STAT     2'h2
`endif

/* File: inc/tqp_pkg.sv */
// Types of the trace qualifier: captured bus state, memory entry, prestore select.
// Assumes tqp_consts.svh is on the include path.
`include "tqp_consts.svh"
package tqp_pkg;
    typedef struct packed {
        logic [`TQP_STAT_W-1:0] stat;
        logic [`TQP_DATA_W-1:0] data;
        logic [`TQP_ADDR_W-1:0] addr;
    } tqp_state_t;

    typedef struct packed {
        logic       pre;
        tqp_state_t st;
    } tqp_entry_t;

    typedef enum logic [1:0] {
        TQP_PRE_ANY,
        TQP_PRE_NONE,
        TQP_PRE_ARM,
        TQP_PRE_EXPR
    } tqp_pre_sel_t;
endpackage

/* File: design/tqp_qualifier.sv */
// Trace qualifier: pattern slots, range term, trigger, prestore pipe, trace memory.
// Assumes one captured bus state per clock with state_valid, and an Avalon-MM master.
// Notes on behaviour
// - Eight named pattern slots, each one expression, usable as terms.
// - A pattern holds one value per label, never a range.
// - Pattern bits beyond a label's width are dropped.
// - Care mask lets bits be don't-care in pattern comparison.
// - After reset or init every pattern slot matches any state.
// - Trigger combines terms by OR and by AND.
// - Pattern terms count only in complex configuration.
// - Prestore selects any, none, arm input, or term expression.
// - Reset or init sets prestore to none.
// - Prestore-qualifying states shift into a two-entry pipe, newest kept.
// - Each stored state writes the pipe first, then empties it.
// - Pipe holds only states since the previous stored state.
// - Prestored entries share trace memory with stored states.
// - Range has an any setting matching every value.
// - Range matches lower to upper inclusive; software keeps lower not above upper.
// - Equal bounds match a single value.
// - Leaving complex configuration resets range to any.
// - Init sets easy configuration with range any.
// - Inverted range term matches states outside the range.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`include "tqp_consts.svh"
module tqp_qualifier
    import tqp_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int MAW   = 10
) (
    input  wire logic                   clock,
    input  wire logic                   srst,
    input  wire logic [`TQP_BUS_AW-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire tqp_state_t             bus_state,
    input  wire logic                   state_valid,
    input  wire logic                   arm_in,
    output logic                        trigger
);
    localparam int NT = `TQP_NTERM;

    // Bus handshake: request taken at first edge, answered one cycle later
    logic        ack;
    logic        req;
    logic        wr_go;
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wr_go           = avs_write & ack;

    logic [`TQP_BUS_AW-1:0] a;
    logic                   pat_sel;
    logic [2:0]             pat_slot;
    logic [2:0]             pat_fld;
    assign a        = avs_address;
    assign pat_sel  = a[`TQP_PAT_BASE_BIT] & (a[4:2] < 3'h6);
    assign pat_slot = a[7:5];
    assign pat_fld  = a[4:2];

    // Configuration
    logic            complex_cfg;
    logic            run;
    tqp_pre_sel_t    pre_sel;
    logic [NT-1:0]   trig_or;
    logic [NT-1:0]   trig_and;
    logic [NT-1:0]   sto_mask;
    logic            sto_all;
    logic [NT-1:0]   pre_mask;
    logic            rng_any;
    logic [1:0]      rng_lab;
    logic [31:0]     rng_lo;
    logic [31:0]     rng_hi;
    logic [MAW-1:0]  mem_idx;
    tqp_state_t      pat_val [`TQP_NPAT];
    tqp_state_t      pat_care[`TQP_NPAT];

    logic init_go;
    logic easy_go;
    assign init_go = wr_go & (a == `TQP_OFF_CTRL) & avs_writedata[`TQP_CTRL_INIT];
    assign easy_go = wr_go & (a == `TQP_OFF_CTRL) & ~avs_writedata[`TQP_CTRL_COMPLEX];

    always_ff @(posedge clock) begin
        if (srst | init_go) begin
            complex_cfg <= 1'b0;
            run         <= 1'b0;
            pre_sel     <= TQP_PRE_NONE;
            trig_or     <= '0;
            trig_and    <= '0;
            sto_mask    <= '0;
            sto_all     <= 1'b1;
            pre_mask    <= '0;
            mem_idx     <= '0;
        end else if (wr_go) begin
            case (a)
                `TQP_OFF_CTRL: begin
                    complex_cfg <= avs_writedata[`TQP_CTRL_COMPLEX];
                    run         <= avs_writedata[`TQP_CTRL_RUN];
                end
                `TQP_OFF_PRESEL:  pre_sel  <= tqp_pre_sel_t'(avs_writedata[1:0]);
                `TQP_OFF_TRIGOR:  trig_or  <= avs_writedata[NT-1:0];
                `TQP_OFF_TRIGAND: trig_and <= avs_writedata[NT-1:0];
                `TQP_OFF_STORE: begin
                    sto_mask <= avs_writedata[NT-1:0];
                    sto_all  <= avs_writedata[`TQP_STORE_ALL];
                end
                `TQP_OFF_PREMASK: pre_mask <= avs_writedata[NT-1:0];
                `TQP_OFF_MEMIDX:  mem_idx  <= avs_writedata[MAW-1:0];
                default: ;
            endcase
        end
    end

    // Range settings; discarded on init and whenever easy config is written
    always_ff @(posedge clock) begin
        if (srst | init_go | easy_go) begin
            rng_any <= 1'b1;
            rng_lab <= `TQP_LAB_ADDR;
            rng_lo  <= '0;
            rng_hi  <= '0;
        end else if (wr_go & complex_cfg) begin
            case (a)
                `TQP_OFF_RNGCFG: begin
                    rng_any <= avs_writedata[0];
                    rng_lab <= avs_writedata[2:1];
                end
                `TQP_OFF_RNGLO: rng_lo <= avs_writedata;
                `TQP_OFF_RNGHI: rng_hi <= avs_writedata;
                default: ;
            endcase
        end
    end

    // Pattern slots: value and care per label; care zero matches anything
    always_ff @(posedge clock) begin
        for (int k = 0; k < `TQP_NPAT; k++) begin
            if (srst | init_go) begin
                pat_val[k]  <= '0;
                pat_care[k] <= '0;
            end else if (wr_go & pat_sel & (pat_slot == 3'(k))) begin
                case (pat_fld)
                    3'h0: pat_val[k].addr  <= avs_writedata[`TQP_ADDR_W-1:0];
                    3'h1: pat_care[k].addr <= avs_writedata[`TQP_ADDR_W-1:0];
                    3'h2: pat_val[k].data  <= avs_writedata[`TQP_DATA_W-1:0];
                    3'h3: pat_care[k].data <= avs_writedata[`TQP_DATA_W-1:0];
                    3'h4: pat_val[k].stat  <= avs_writedata[`TQP_STAT_W-1:0];
                    3'h5: pat_care[k].stat <= avs_writedata[`TQP_STAT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Capture stage
    tqp_state_t s1;
    logic       v1;
    logic       arm1;
    always_ff @(posedge clock) begin
        if (srst) begin
            s1   <= '0;
            v1   <= 1'b0;
            arm1 <= 1'b0;
        end else begin
            s1   <= bus_state;
            v1   <= state_valid & run;
            arm1 <= arm_in;
        end
    end

    // Term evaluation on the captured state
    logic [`TQP_NPAT-1:0] pat_hit;
    genvar g;
    generate
        for (g = 0; g < `TQP_NPAT; g++) begin : g_pat
            assign pat_hit[g] = ~|((s1 ^ pat_val[g]) & pat_care[g]);
        end
    endgenerate

    logic [31:0] rng_in;
    logic [31:0] lo_w;
    logic [31:0] hi_w;
    logic        rng_hit;
    logic        lab_stat;
    assign lab_stat = (rng_lab == `TQP_LAB_STAT);
    assign rng_in   = (rng_lab == `TQP_LAB_DATA) ? s1.data :
                      lab_stat ? {16'h0, s1.stat} : s1.addr;
    // Stat label compares only the low 16 bits of both bounds
    assign lo_w     = lab_stat ? {16'h0, rng_lo[15:0]} : rng_lo;
    assign hi_w     = lab_stat ? {16'h0, rng_hi[15:0]} : rng_hi;
    assign rng_hit  = rng_any | ((rng_in >= lo_w) & (rng_in <= hi_w));

    logic [NT-1:0] terms;
    assign terms = {arm1,
                    ~rng_hit & complex_cfg,
                    rng_hit & complex_cfg,
                    pat_hit & {`TQP_NPAT{complex_cfg}}};

    tqp_state_t    s2;
    logic          v2;
    logic [NT-1:0] t2;
    always_ff @(posedge clock) begin
        if (srst) begin
            s2 <= '0;
            v2 <= 1'b0;
            t2 <= '0;
        end else begin
            s2 <= s1;
            v2 <= v1;
            t2 <= terms;
        end
    end

    // Trigger, store and prestore decisions
    logic trig_hit;
    logic store_hit;
    logic pre_hit;
    assign trig_hit  = (|(t2 & trig_or)) | ((|trig_and) & (&(t2 | ~trig_and)));
    assign store_hit = v2 & (sto_all | (|(t2 & sto_mask)));
    assign pre_hit   = (pre_sel == TQP_PRE_ANY)  |
                       ((pre_sel == TQP_PRE_ARM)  & t2[`TQP_TERM_ARM]) |
                       ((pre_sel == TQP_PRE_EXPR) & (|(t2 & pre_mask)));

    always_ff @(posedge clock) begin
        if (srst) begin
            trigger <= 1'b0;
        end else begin
            trigger <= v2 & trig_hit;
        end
    end

    // Prestore pipe and shared trace memory
    tqp_entry_t     mem [DEPTH];
    tqp_state_t     pipe0;
    tqp_state_t     pipe1;
    logic [1:0]     pcnt;
    logic [MAW-1:0] wp;
    logic [MAW:0]   fill;
    logic [MAW-1:0] wp1;
    logic [MAW-1:0] wp2;
    logic [MAW:0]   next_fill;
    assign wp1       = wp + MAW'(1);
    assign wp2       = wp + MAW'(2);
    assign next_fill = fill + {{(MAW-1){1'b0}}, pcnt} + (MAW+1)'(1);

    always_ff @(posedge clock) begin
        if (store_hit) begin
            case (pcnt)
                2'h2: begin
                    mem[wp]  <= '{pre: 1'b1, st: pipe0};
                    mem[wp1] <= '{pre: 1'b1, st: pipe1};
                    mem[wp2] <= '{pre: 1'b0, st: s2};
                end
                2'h1: begin
                    mem[wp]  <= '{pre: 1'b1, st: pipe0};
                    mem[wp1] <= '{pre: 1'b0, st: s2};
                end
                default: mem[wp] <= '{pre: 1'b0, st: s2};
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst | init_go) begin
            pipe0 <= '0;
            pipe1 <= '0;
            pcnt  <= 2'h0;
            wp    <= '0;
            fill  <= '0;
        end else if (store_hit) begin
            pcnt <= 2'h0;
            wp   <= wp + MAW'(pcnt) + MAW'(1);
            fill <= (next_fill > (MAW+1)'(DEPTH)) ? (MAW+1)'(DEPTH) : next_fill;
        end else if (v2 & pre_hit) begin
            if (pcnt == 2'h2) begin
                pipe0 <= pipe1;
                pipe1 <= s2;
            end else if (pcnt == 2'h1) begin
                pipe1 <= s2;
                pcnt  <= 2'h2;
            end else begin
                pipe0 <= s2;
                pcnt  <= 2'h1;
            end
        end
    end

    // Read path
    tqp_entry_t  rd_ent;
    logic [31:0] pat_rd;
    logic [31:0] rd_mux;
    assign rd_ent = mem[mem_idx];
    always_comb begin
        pat_rd = 32'h0;
        case (pat_fld)
            3'h0: pat_rd = pat_val[pat_slot].addr;
            3'h1: pat_rd = pat_care[pat_slot].addr;
            3'h2: pat_rd = pat_val[pat_slot].data;
            3'h3: pat_rd = pat_care[pat_slot].data;
            3'h4: pat_rd = {16'h0, pat_val[pat_slot].stat};
            3'h5: pat_rd = {16'h0, pat_care[pat_slot].stat};
            default: pat_rd = 32'h0;
        endcase
    end

    always_comb begin
        rd_mux = 32'h0;
        if (pat_sel) begin
            rd_mux = pat_rd;
        end else begin
            case (a)
                `TQP_OFF_CTRL:    rd_mux = {29'h0, run, 1'b0, complex_cfg};
                `TQP_OFF_PRESEL:  rd_mux = {30'h0, pre_sel};
                `TQP_OFF_TRIGOR:  rd_mux = {21'h0, trig_or};
                `TQP_OFF_TRIGAND: rd_mux = {21'h0, trig_and};
                `TQP_OFF_STORE:   rd_mux = {15'h0, sto_all, 5'h0, sto_mask};
                `TQP_OFF_PREMASK: rd_mux = {21'h0, pre_mask};
                `TQP_OFF_RNGCFG:  rd_mux = {29'h0, rng_lab, rng_any};
                `TQP_OFF_RNGLO:   rd_mux = rng_lo;
                `TQP_OFF_RNGHI:   rd_mux = rng_hi;
                `TQP_OFF_STATUS:  rd_mux = {(16-MAW-1)'(0), fill, 13'h0, pcnt, trigger};
                `TQP_OFF_MEMIDX:  rd_mux = {(32-MAW)'(0), mem_idx};
                `TQP_OFF_MEMA:    rd_mux = rd_ent.st.addr;
                `TQP_OFF_MEMD:    rd_mux = rd_ent.st.data;
                `TQP_OFF_MEMS:    rd_mux = {15'h0, rd_ent.pre, rd_ent.st.stat};
                default:          rd_mux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= req & ~ack;
            if (avs_read & ~ack) begin
                avs_readdata <= rd_mux;
            end
        end
    end
endmodule // tqp_qualifier

/* File: dv/tqp_chk.sv */
// Checker of the trace qualifier: bus handshake, reset values, trigger timing.
// Assumes it is bound to tqp_qualifier and sees only that module's ports.
`include "tqp_consts.svh"
module tqp_chk
    import tqp_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int MAW   = 10
) (
    input wire logic                   clock,
    input wire logic                   srst,
    input wire logic [`TQP_BUS_AW-1:0] avs_address,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_readdata,
    input wire logic                   avs_waitrequest,
    input wire logic                   state_valid,
    input wire logic                   trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    logic      wr_seen;
    wire logic req     = avs_read | avs_write;
    wire logic rd_done = avs_read & ~avs_waitrequest;
    // Reset values are only judged until software first writes
    always_ff @(posedge clock) begin
        if (srst)
            wr_seen <= 1'h0;
        else if (avs_write && !avs_waitrequest)
            wr_seen <= 1'h1;
    end
    wire logic fresh = rd_done & ~wr_seen;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_take; req && avs_waitrequest; endsequence
    sequence s_done; req && !avs_waitrequest; endsequence
    property p_one_wait; s_take |=> s_done; endproperty
    a_one_wait: assert property (p_one_wait) else $error("request not answered after one wait");
    property p_idle_free; !req |-> !avs_waitrequest; endproperty
    a_idle_free: assert property (p_idle_free) else $error("wait raised with no request");
    property p_rd_held; !avs_read |=> $stable(avs_readdata); endproperty
    a_rd_held: assert property (p_rd_held) else $error("read data changed without a read");
    property p_trig_cause; trigger |-> $past(state_valid, 3); endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without a state");
    property p_rst_ctrl; fresh && avs_address == `TQP_OFF_CTRL |-> avs_readdata[2:0] == 3'h0; endproperty
    a_rst_ctrl: assert property (p_rst_ctrl) else $error("control not easy after reset");
    property p_rst_presel; fresh && avs_address == `TQP_OFF_PRESEL |-> avs_readdata[1:0] == 2'h1; endproperty
    a_rst_presel: assert property (p_rst_presel) else $error("prestore not none after reset");
    property p_rst_rng; fresh && avs_address == `TQP_OFF_RNGCFG |-> avs_readdata[0]; endproperty
    a_rst_rng: assert property (p_rst_rng) else $error("range not any after reset");
    property p_rst_pat; fresh && avs_address[8] && avs_address[2] |-> avs_readdata == 32'h0; endproperty
    a_rst_pat: assert property (p_rst_pat) else $error("pattern care not clear after reset");
endmodule // tqp_chk

bind tqp_qualifier tqp_chk #(.DEPTH(DEPTH), .MAW(MAW)) u_chk (
    .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .state_valid(state_valid),
    .trigger(trigger));

/* File: dv/tqp_bus_model.sv */
// Observed processor bus: hands one captured state and the arm level to the qualifier.
// Assumes the bench calls send between clock edges of its own sequence.
module tqp_bus_model
    import tqp_pkg::*;
(
    input wire logic  clock,
    output tqp_state_t bus_state,
    output logic       state_valid,
    output logic       arm_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus_state = '0;
        state_valid = 1'h0;
        arm_in = 1'h0;
    end
    task send(input tqp_state_t s, input logic a);
        @(posedge clock);
        bus_state <= s;
        state_valid <= 1'h1;
        arm_in <= a;
        @(posedge clock);
        state_valid <= 1'h0;
        arm_in <= 1'h0;
        // Idle lines never keep the last state
        bus_state <= ~s;
    endtask
endmodule // tqp_bus_model

/* File: dv/tqp_qualifier_tb.sv */
// Testbench of the trace qualifier: register tasks on Avalon-MM, states from the bus model.
// Assumes DEPTH 16 so that memory indices stay small.
`include "tqp_consts.svh"
module tqp_qualifier_tb
    import tqp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clock, srst, avs_read, avs_write, avs_waitrequest, trigger, state_valid, arm_in;
    logic [`TQP_BUS_AW-1:0] avs_address;
    logic [31:0]            avs_writedata, avs_readdata, q;
    tqp_state_t             bus_state;
    int                     n_mismatch, n_compared, n_trig, n_cyc;

    tqp_qualifier #(.DEPTH(16), .MAW(4)) dut (.clock(clock), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_state(bus_state), .state_valid(state_valid), .arm_in(arm_in),
        .trigger(trigger));
    tqp_bus_model m (.clock(clock), .bus_state(bus_state), .state_valid(state_valid), .arm_in(arm_in));

    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        n_cyc++;
        if (trigger === 1'h1)
            n_trig++;
        if (n_cyc == 8000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clock);
        while (avs_waitrequest)
            @(posedge clock);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task wr(input logic [8:0] a, input logic [31:0] d);
        acc(1'h1, a, d);
    endtask
    task rc(input logic [8:0] a, input logic [31:0] msk, input logic [31:0] e);
        acc(1'h0, a, 32'h0);
        chk(q & msk, e);
    endtask
    // One state, then the trigger count it must have caused
    task st(input logic [31:0] a, input logic [15:0] s, input logic [31:0] d, input logic arm, input logic [31:0] e);
        int n0;
        n0 = n_trig;
        m.send({s, d, a}, arm);
        repeat (5) @(posedge clock);
        chk(32'(n_trig - n0), e);
    endtask
    task ps(input logic [31:0] a);
        st(a, 16'h0, 32'h0, 1'h0, 32'h0);
    endtask
    task mc(input logic [31:0] i, input logic [31:0] a, input logic [31:0] f);
        wr(`TQP_OFF_MEMIDX, i);
        rc(`TQP_OFF_MEMA, 32'hffff_ffff, a);
        rc(`TQP_OFF_MEMS, 32'h0001_0000, f << 16);
    endtask

    initial begin
        srst = 1'h1;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_address = 9'h0;
        avs_writedata = 32'h0;
        repeat (4) @(posedge clock);
        srst <= 1'h0;
        rc(`TQP_OFF_CTRL, 32'h5, 32'h0);
        rc(`TQP_OFF_PRESEL, 32'h3, 32'h1);
        rc(`TQP_OFF_RNGCFG, 32'h1, 32'h1);
        rc(9'h104, 32'hffff_ffff, 32'h0);
        rc(9'h1f4, 32'hffff_ffff, 32'h0);
        rc(`TQP_OFF_STORE, 32'h0001_07ff, 32'h0001_0000);
        wr(9'h0fc, 32'hffff_ffff);
        rc(9'h0fc, 32'hffff_ffff, 32'h0);
        $display("test reset done");
        wr(`TQP_OFF_CTRL, 32'h4);
        wr(`TQP_OFF_RNGCFG, 32'h0);
        rc(`TQP_OFF_RNGCFG, 32'h1, 32'h1);
        wr(9'h100, 32'h100);
        wr(9'h104, 32'hffff_ffff);
        wr(`TQP_OFF_TRIGOR, 32'h1);
        st(32'h100, 16'h0, 32'h0, 1'h0, 32'h0);
        wr(`TQP_OFF_CTRL, 32'h5);
        st(32'h100, 16'h0, 32'h0, 1'h0, 32'h1);
        wr(9'h104, 32'hffff_fffc);
        st(32'h103, 16'h0, 32'h0, 1'h0, 32'h1);
        st(32'h104, 16'h0, 32'h0, 1'h0, 32'h0);
        wr(9'h130, 32'h0003_0002);
        wr(9'h134, 32'h0000_ffff);
        wr(`TQP_OFF_TRIGOR, 32'h0);
        wr(`TQP_OFF_TRIGAND, 32'h3);
        st(32'h100, 16'h2, 32'h0, 1'h0, 32'h1);
        st(32'h100, 16'h1, 32'h0, 1'h0, 32'h0);
        st(32'h200, 16'h2, 32'h0, 1'h0, 32'h0);
        wr(9'h1e8, 32'h20);
        wr(9'h1ec, 32'hffff_ffff);
        wr(`TQP_OFF_TRIGAND, 32'h0);
        wr(`TQP_OFF_TRIGOR, 32'h480);
        st(32'h0, 16'h0, 32'h20, 1'h0, 32'h1);
        st(32'h0, 16'h0, 32'h21, 1'h0, 32'h0);
        st(32'h0, 16'h0, 32'h21, 1'h1, 32'h1);
        $display("test patterns done");
        wr(`TQP_OFF_RNGCFG, 32'h0);
        wr(`TQP_OFF_RNGLO, 32'h200);
        wr(`TQP_OFF_RNGHI, 32'h2ff);
        wr(`TQP_OFF_TRIGOR, 32'h100);
        st(32'h1ff, 16'h0, 32'h0, 1'h0, 32'h0);
        st(32'h200, 16'h0, 32'h0, 1'h0, 32'h1);
        st(32'h2ff, 16'h0, 32'h0, 1'h0, 32'h1);
        st(32'h300, 16'h0, 32'h0, 1'h0, 32'h0);
        wr(`TQP_OFF_TRIGOR, 32'h200);
        st(32'h300, 16'h0, 32'h0, 1'h0, 32'h1);
        st(32'h250, 16'h0, 32'h0, 1'h0, 32'h0);
        wr(`TQP_OFF_RNGLO, 32'h250);
        wr(`TQP_OFF_RNGHI, 32'h250);
        wr(`TQP_OFF_TRIGOR, 32'h100);
        st(32'h250, 16'h0, 32'h0, 1'h0, 32'h1);
        st(32'h251, 16'h0, 32'h0, 1'h0, 32'h0);
        wr(`TQP_OFF_RNGCFG, 32'h2);
        st(32'h0, 16'h0, 32'h250, 1'h0, 32'h1);
        st(32'h250, 16'h0, 32'h0, 1'h0, 32'h0);
        wr(`TQP_OFF_RNGCFG, 32'h4);
        st(32'h0, 16'h250, 32'h0, 1'h0, 32'h1);
        st(32'h0, 16'h251, 32'h0, 1'h0, 32'h0);
        wr(`TQP_OFF_CTRL, 32'h4);
        wr(`TQP_OFF_CTRL, 32'h5);
        rc(`TQP_OFF_RNGCFG, 32'h1, 32'h1);
        st(32'h123, 16'h0, 32'h0, 1'h0, 32'h1);
        $display("test range done");
        wr(`TQP_OFF_CTRL, 32'h2);
        rc(`TQP_OFF_PRESEL, 32'h3, 32'h1);
        wr(`TQP_OFF_CTRL, 32'h5);
        wr(`TQP_OFF_TRIGOR, 32'h0);
        wr(9'h140, 32'h500);
        wr(9'h144, 32'hffff_ffff);
        wr(`TQP_OFF_STORE, 32'h4);
        wr(`TQP_OFF_PRESEL, 32'h0);
        ps(32'h10);
        ps(32'h11);
        ps(32'h12);
        ps(32'h500);
        rc(`TQP_OFF_STATUS, 32'h07ff_0000, 32'h0003_0000);
        mc(32'h0, 32'h11, 32'h1);
        mc(32'h1, 32'h12, 32'h1);
        mc(32'h2, 32'h500, 32'h0);
        ps(32'h13);
        ps(32'h500);
        mc(32'h3, 32'h13, 32'h1);
        mc(32'h4, 32'h500, 32'h0);
        wr(`TQP_OFF_PRESEL, 32'h1);
        ps(32'h14);
        ps(32'h500);
        mc(32'h5, 32'h500, 32'h0);
        wr(`TQP_OFF_PRESEL, 32'h2);
        st(32'h15, 16'h0, 32'h0, 1'h1, 32'h0);
        ps(32'h16);
        ps(32'h500);
        mc(32'h6, 32'h15, 32'h1);
        wr(`TQP_OFF_PRESEL, 32'h3);
        wr(`TQP_OFF_PREMASK, 32'h8);
        wr(9'h160, 32'h18);
        wr(9'h164, 32'hffff_ffff);
        ps(32'h18);
        ps(32'h19);
        ps(32'h500);
        mc(32'h8, 32'h18, 32'h1);
        mc(32'h9, 32'h500, 32'h0);
        rc(`TQP_OFF_STATUS, 32'h07ff_0000, 32'h000a_0000);
        $display("test prestore done");
        report_and_stop();
    end
endmodule // tqp_qualifier_tb
